// >>> sar_adc_pkg.sv
// package: register map, field layout and timing constants of the converter control
// assumes: apb slave with 32-bit data, one aligned word per register
package sar_adc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS_CTRL = 8'h00;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h04;
  localparam logic [7:0] OFF_RESULT_LOW  = 8'h08;
  localparam logic [7:0] OFF_CLOCK_CFG   = 8'h0C;
  // status_control_reg fields
  localparam int CHAN_LSB   = 0;
  localparam int CHAN_W     = 5;
  localparam int CONT_BIT   = 5;
  localparam int IRQEN_BIT  = 6;
  localparam int DONE_BIT   = 7;
  // clock_cfg_reg fields
  localparam int ICLK_BIT   = 0;
  localparam int MODE_BIT   = 2;
  localparam int LSMP_BIT   = 4;
  localparam int DIV_LSB    = 5;
  localparam int DIV_W      = 2;
  localparam int LPC_BIT    = 7;
  localparam int ACLK_BIT   = 8;
  localparam logic [CHAN_W-1:0] CHAN_OFF = 5'h1F;
  // conversion lengths in converter clocks, steady continuous figures
  localparam logic [5:0] CYC_8_SHORT  = 6'h10;
  localparam logic [5:0] CYC_8_LONG   = 6'h24;
  localparam logic [5:0] CYC_10_SHORT = 6'h13;
  localparam logic [5:0] CYC_10_LONG  = 6'h27;
  localparam logic [5:0] CYC_FIRST_EXTRA = 6'h02;
  localparam logic [1:0] BUS_SYNC_CYC = 2'h3;
  // async clock startup
  localparam int CLK_MHZ = 50;
  localparam int STARTUP_US = 5;
  localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SYNC  = 4'b0010,
    ST_WARM  = 4'b0100,
    ST_CONV  = 4'b1000
  } conv_state_t;
endpackage : sar_adc_pkg

// >>> sar_adc_control.sv
// file: control logic of a 10-bit successive-approximation converter, apb register slave
// assumes: analog core returns a raw 10-bit code on sarCode; clock sources arrive as pins
// Functional notes
// - source is async clock if async_clk_en, else bus or alternate by input_clk_sel.
// - async oscillator range follows low_power_cfg; driven out as oscLowPower.
// - async oscillator enabled only while converting on it; runs through stop.
// - selected source divided by 1, 2, 4 or 8 from clk_div.
// - one channel from chan_sel routed to the converter; codes at or above NUM_CHAN route none.
// - 10-bit result over high and low registers; 8-bit rounded into low.
// - status_control_reg write starts conversion unless chan_sel is all ones.
// - no hardware trigger; only software writes, continuous mode or a blocked transfer start.
// - continuous mode restarts after each transfer until aborted.
// - completion transfers result, sets conv_done; irq only if irq_en then.
// - 10-bit, high read but low unread: transfer blocked, result discarded.
// - a blocked transfer starts another conversion unless an abort comes in the same cycle.
// - abort on control write, clock write, reset, or stop without async clock.
// - abort keeps last result unless a completion falls in its cycle; reset clears results.
// - reset or abort drops the converter to its idle low-power state at once.
// - 8-bit short: first 18 clocks plus 3 bus clocks, later 16.
// - 8-bit long: first 38 clocks plus 3 bus clocks, later 36.
// - 10-bit short: first 21 clocks plus 3 bus clocks, later 19.
// - 10-bit long: first 41 clocks plus 3 bus clocks, later 39.
// - async clock adds up to 5 us startup to a first conversion.
// - conv_done sets at every unblocked completion regardless of irq_en.
// - chan_sel all ones powers the converter down.
`timescale 1ns/1ns
module sar_adc_control
  import sar_adc_pkg::*;
#(
  parameter int NUM_CHAN  = 16,
  parameter int STARTUP   = STARTUP_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        oscAltClk,
  input  wire logic        asyncClk,
  input  wire logic        stopReq,
  input  wire logic [9:0]  sarCode,
  output logic [NUM_CHAN-1:0] chanOneHot,
  output logic             asyncOscEn,
  output logic             oscLowPower,
  output logic             convActive,
  output logic             irqReq
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // pin clocks are oversampled, so each must stay under a quarter of mclk
  logic [1:0] altS_q, asyS_q, stopS_q;
  logic altD_q, asyD_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      altS_q  <= 2'h0;
      asyS_q  <= 2'h0;
      stopS_q <= 2'h0;
      altD_q  <= 1'b0;
      asyD_q  <= 1'b0;
    end else begin
      altS_q  <= {altS_q[0], oscAltClk};
      asyS_q  <= {asyS_q[0], asyncClk};
      stopS_q <= {stopS_q[0], stopReq};
      altD_q  <= altS_q[1];
      asyD_q  <= asyS_q[1];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [CHAN_W-1:0] chan_q;
  logic cont_q, irqEn_q, done_q;
  logic iclk_q, mode10_q, lsmp_q, lpc_q, aclk_q;
  logic [DIV_W-1:0] div_q;
  logic [1:0] resHi_q;
  logic [7:0] resLo_q;
  logic hiRead_q;
  logic setup, wrCtrl, wrClk, rdHigh, rdLow, complete, blocked;
  assign setup  = psel && !penable;
  assign wrCtrl = setup && pwrite && paddr == OFF_STATUS_CTRL;
  assign wrClk  = setup && pwrite && paddr == OFF_CLOCK_CFG;
  assign rdHigh = setup && !pwrite && paddr == OFF_RESULT_HIGH;
  assign rdLow  = setup && !pwrite && paddr == OFF_RESULT_LOW;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chan_q  <= CHAN_OFF;
      cont_q  <= 1'b0;
      irqEn_q <= 1'b0;
    end else if (wrCtrl) begin
      chan_q  <= pwdata[CHAN_LSB +: CHAN_W];
      cont_q  <= pwdata[CONT_BIT];
      irqEn_q <= pwdata[IRQEN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      iclk_q <= 1'b0;
      mode10_q <= 1'b0;
      lsmp_q <= 1'b0;
      div_q  <= '0;
      lpc_q  <= 1'b0;
      aclk_q <= 1'b0;
    end else if (wrClk) begin
      iclk_q <= pwdata[ICLK_BIT];
      mode10_q <= pwdata[MODE_BIT];
      lsmp_q <= pwdata[LSMP_BIT];
      div_q  <= pwdata[DIV_LSB +: DIV_W];
      lpc_q  <= pwdata[LPC_BIT];
      aclk_q <= pwdata[ACLK_BIT];
    end
  end

  // high-read tracking
  // cleared by a low read, so the next high read opens a fresh pair
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) hiRead_q <= 1'b0;
    else if (rdHigh && mode10_q) hiRead_q <= 1'b1;
    else if (rdLow) hiRead_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // converter clock select and divide
  // ----------------------------------------------------------------
  function automatic logic [5:0] conv_len(input logic m10, input logic ls);
    if (m10) conv_len = ls ? CYC_10_LONG : CYC_10_SHORT;
    else conv_len = ls ? CYC_8_LONG : CYC_8_SHORT;
  endfunction

  conv_state_t st_q;
  logic srcLvl, srcPrev_q, srcEdge, ckEn;
  logic [2:0] divCnt_q;
  always_comb begin
    if (aclk_q) srcLvl = asyD_q;
    else if (iclk_q) srcLvl = divCnt_q[0];
    else srcLvl = altD_q;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) srcPrev_q <= 1'b0;
    else srcPrev_q <= srcLvl;
  end
  // bus clock source ticks every cycle; pin clocks tick on rising edge
  assign srcEdge = iclk_q && !aclk_q ? 1'b1 : (srcLvl && !srcPrev_q);
  logic [2:0] divMask;
  assign divMask = 3'((4'h1 << div_q) - 4'h1);
  logic [2:0] srcCnt_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) srcCnt_q <= 3'h0;
    else if (st_q == ST_IDLE) srcCnt_q <= 3'h0;
    else if (srcEdge) srcCnt_q <= (srcCnt_q & divMask) == divMask ? 3'h0 : srcCnt_q + 3'h1;
  end
  assign ckEn = srcEdge && (srcCnt_q & divMask) == divMask;
  // free-running count, bit 0 gives the mclk/2 level of the bus source
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) divCnt_q <= 3'h0;
    else divCnt_q <= divCnt_q + 3'h1;
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  logic first_q, abort, startSw;
  logic [5:0] ckCnt_q;
  logic [1:0] syncCnt_q;
  logic [$clog2(STARTUP+1)-1:0] warm_q;
  // abort sources
  // stop leaves the async clock running, so it only aborts on the other sources
  assign abort = wrCtrl || wrClk || (stopS_q[1] && !aclk_q);
  assign startSw = wrCtrl && pwdata[CHAN_LSB +: CHAN_W] != CHAN_OFF;
  assign complete = st_q == ST_CONV && ckEn && ckCnt_q == 6'h01;
  assign blocked = complete && mode10_q && hiRead_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      first_q <= 1'b0;
      ckCnt_q <= '0;
      syncCnt_q <= '0;
      warm_q <= '0;
    end else if (startSw) begin
      // a start beats the abort its own write raises, so the write restarts at once
      // first conversion pays bus sync
      st_q <= ST_SYNC;
      first_q <= 1'b1;
      syncCnt_q <= BUS_SYNC_CYC;
    end else if (abort) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: st_q <= ST_IDLE;
        ST_SYNC: begin
          // three bus cycles hand the request over to the converter clock
          syncCnt_q <= syncCnt_q - 2'h1;
          if (syncCnt_q == 2'h1) begin
            // async startup
            // warm-up counts mclk cycles, so STARTUP must track the bus frequency
            st_q <= aclk_q ? ST_WARM : ST_CONV;
            warm_q <= ($clog2(STARTUP+1))'(STARTUP);
            ckCnt_q <= conv_len(mode10_q, lsmp_q) + CYC_FIRST_EXTRA;
          end
        end
        ST_WARM: begin
          warm_q <= warm_q - 1'b1;
          if (warm_q == '0) st_q <= ST_CONV;
        end
        ST_CONV: begin
          if (ckEn) ckCnt_q <= ckCnt_q - 6'h01;
          if (complete) begin
            first_q <= 1'b0;
            if (cont_q || blocked) begin
              ckCnt_q <= conv_len(mode10_q, lsmp_q);
            end else st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result transfer and flag
  // ----------------------------------------------------------------
  logic [9:0] rnd8;
  // round to 8 bits, saturating
  // saturating keeps the top code from wrapping round to zero
  assign rnd8 = sarCode[9:2] == 8'hFF ? 10'h0FF : 10'({2'h0, sarCode[9:2]} + {9'h0, sarCode[1]});
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resHi_q <= 2'h0;
      resLo_q <= 8'h00;
    end else if (complete && !blocked) begin
      resHi_q <= mode10_q ? sarCode[9:8] : 2'h0;
      resLo_q <= mode10_q ? sarCode[7:0] : rnd8[7:0];
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) done_q <= 1'b0;
    else if (complete && !blocked) done_q <= 1'b1;
    else if (wrCtrl || rdLow) done_q <= 1'b0;
  end
  // irq follows irq_en only at the moment the flag sets
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) irqReq <= 1'b0;
    else if (complete && !blocked) irqReq <= irqEn_q;
    else if (wrCtrl || rdLow) irqReq <= 1'b0;
  end

  // ----------------------------------------------------------------
  // analog side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chanOneHot <= '0;
      asyncOscEn <= 1'b0;
      oscLowPower <= 1'b0;
      convActive <= 1'b0;
    end else begin
      // one-hot routing, none when idle
      // channel codes at or above NUM_CHAN route nothing
      chanOneHot <= (st_q != ST_IDLE && !abort && int'(chan_q) < NUM_CHAN) ? NUM_CHAN'(1) << chan_q : '0;
      // async oscillator only while converting on it
      asyncOscEn <= aclk_q && st_q != ST_IDLE && !abort;
      oscLowPower <= lpc_q;
      // power drops with the abort itself, not a cycle later
      convActive <= st_q != ST_IDLE && !abort;
    end
  end

  // ----------------------------------------------------------------
  // apb read path, zero-wait
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      // writes and read side effects act at setup, so the access phase never waits
      if (setup) begin
        if (paddr == OFF_STATUS_CTRL)
          prdata <= 32'({done_q, irqEn_q, cont_q, chan_q});
        else if (paddr == OFF_RESULT_HIGH) prdata <= 32'(resHi_q);
        else if (paddr == OFF_RESULT_LOW) prdata <= 32'(resLo_q);
        else if (paddr == OFF_CLOCK_CFG)
          prdata <= 32'({aclk_q, lpc_q, div_q, lsmp_q, 1'b0, mode10_q, 1'b0, iclk_q});
        else begin
          // unmapped offsets answer with an error and read as zero
          prdata <= 32'h0;
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_START: assert property (@(posedge mclk) disable iff (!rst_n)
    startSw |=> st_q == ST_SYNC) else $error("start not taken");
  AST_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    wrCtrl && !startSw |=> st_q == ST_IDLE) else $error("power-down not idle");
  AST_ABORT: assert property (@(posedge mclk) disable iff (!rst_n)
    wrClk |=> st_q == ST_IDLE) else $error("clock write did not abort");
  AST_DONE: assert property (@(posedge mclk) disable iff (!rst_n)
    complete && !blocked |=> done_q) else $error("done not set");
  AST_BLOCK: assert property (@(posedge mclk) disable iff (!rst_n)
    blocked && !abort |=> $stable(resLo_q) && $stable(resHi_q) && st_q == ST_CONV) else $error("block failed");
  AST_IRQ: assert property (@(posedge mclk) disable iff (!rst_n)
    complete && !blocked && !irqEn_q && !irqReq |=> !irqReq) else $error("irq without enable");
  AST_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    abort && !complete |=> $stable(resLo_q)) else $error("abort changed result");
  AST_SYNC: assert property (@(posedge mclk) disable iff (!rst_n)
    startSw ##1 !abort [*3] |=> st_q != ST_SYNC) else $error("sync not 3 cycles");
  AST_OSC: assert property (@(posedge mclk) disable iff (!rst_n)
    asyncOscEn |-> aclk_q) else $error("async osc on while unselected");
  AST_ROUTE: assert property (@(posedge mclk) disable iff (!rst_n)
    !convActive |-> chanOneHot == '0) else $error("channel routed while idle");
  AST_ONEHOT: assert property (@(posedge mclk) disable iff (!rst_n)
    $onehot0(chanOneHot)) else $error("more than one channel routed");
  AST_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrCtrl || rdLow) && !(complete && !blocked) |=> !done_q && !irqReq) else $error("flag not cleared");
  AST_IRQSET: assert property (@(posedge mclk) disable iff (!rst_n)
    complete && !blocked && irqEn_q |=> irqReq) else $error("irq not raised");
  AST_CONT: assert property (@(posedge mclk) disable iff (!rst_n)
    complete && cont_q && !abort |=> st_q == ST_CONV) else $error("continuous run stopped");
  AST_HIREAD: assert property (@(posedge mclk) disable iff (!rst_n)
    rdLow |=> !hiRead_q) else $error("pair tracking not released");

  // ----------------------------------------------------------------
  // conversion length in converter clocks
  // ----------------------------------------------------------------
  // tick count
  logic [5:0] tickCnt_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tickCnt_q <= 6'h00;
    else if (st_q != ST_CONV || complete) tickCnt_q <= 6'h00;
    else if (ckEn) tickCnt_q <= tickCnt_q + 6'h01;
  end
  AST_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
    complete |-> tickCnt_q + 6'h01 == (first_q ? conv_len(mode10_q, lsmp_q) + CYC_FIRST_EXTRA
      : conv_len(mode10_q, lsmp_q))) else $error("conversion length wrong");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  COV_SINGLE: cover property (@(posedge mclk) disable iff (!rst_n) complete && !cont_q);
  COV_CONT: cover property (@(posedge mclk) disable iff (!rst_n) complete && cont_q);
  COV_BLOCK: cover property (@(posedge mclk) disable iff (!rst_n) blocked);
  COV_LATER: cover property (@(posedge mclk) disable iff (!rst_n) complete && !first_q);
  COV_ASYNC: cover property (@(posedge mclk) disable iff (!rst_n) complete && aclk_q);
endmodule : sar_adc_control

// >>> sar_adc_control_test.sv
// self-checking bench of the converter control block
// assumes: STARTUP cut to 4 cycles; bench drives every port itself
`timescale 1ns/1ns
module sar_adc_control_test;
  import sar_adc_pkg::*;
  localparam int NCH = 16;
  logic           mclk, rst_n, psel, penable, pwrite, stopReq;
  logic           oscAltClk = 1'b0;
  logic           asyncClk  = 1'b0;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, rd, seed, lastLow;
  logic           pready, pslverr, asyncOscEn, oscLowPower, convActive, irqReq, err;
  logic [9:0]     sarCode, code;
  logic [NCH-1:0] chanOneHot;
  int             nErrors, nCompared, cyc;
  int             divCnt = 0;
  sar_adc_control #(.NUM_CHAN(NCH), .STARTUP(4)) uut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .oscAltClk(oscAltClk), .asyncClk(asyncClk),
    .stopReq(stopReq), .sarCode(sarCode), .chanOneHot(chanOneHot), .asyncOscEn(asyncOscEn),
    .oscLowPower(oscLowPower), .convActive(convActive), .irqReq(irqReq));
  // ----------------------------------------
  // clocks and helpers
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // slow sources stay well under a quarter of mclk so their synchronisers keep up
  always @(posedge mclk) begin
    divCnt <= divCnt + 1;
    if (divCnt % 3 == 2) oscAltClk <= ~oscAltClk;
    if (divCnt % 4 == 3) asyncClk <= ~asyncClk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic int lenOf(input logic m10, input logic ls);
    if (m10) return ls ? int'(CYC_10_LONG) : int'(CYC_10_SHORT);
    return ls ? int'(CYC_8_LONG) : int'(CYC_8_SHORT);
  endfunction : lenOf
  // 8-bit result is the rounded code, saturating at the top
  function automatic logic [31:0] expLow(input logic m10, input logic [9:0] c);
    int r;
    r = (int'(c) + 2) >> 2;
    if (m10) return {24'h0, c[7:0]};
    return (r > 255) ? 32'h000000FF : 32'(r);
  endfunction : expLow
  task automatic printVerdict();
    $display("compared %0d errors %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : printVerdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      chk("pready", 32'h1, 32'h0);
      printVerdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic waitIrq(input int lim, input logic [4:0] ch, input logic aon);
    cyc = 0;
    while (irqReq !== 1'b1 && cyc <= lim) begin
      @(posedge mclk);
      cyc++;
      if (cyc == 6) chk("onehot", 32'(NCH'(1) << ch), 32'(chanOneHot));
      if (cyc == 6) chk("asyncOscEn", 32'(aon), 32'(asyncOscEn));
    end
  endtask : waitIrq
  task automatic checkResult(input logic m10);
    apb(1'b0, OFF_STATUS_CTRL, 32'h0);
    chk("conv_done", 32'h1, 32'(rd[DONE_BIT]));
    apb(1'b0, OFF_RESULT_HIGH, 32'h0);
    chk("result_high", m10 ? 32'(code[9:8]) : 32'h0, rd);
    apb(1'b0, OFF_RESULT_LOW, 32'h0);
    chk("result_low", expLow(m10, code), rd);
    lastLow = rd;
    chk("irq cleared", 32'h0, 32'(irqReq));
  endtask : checkResult
  // src 0 alternate, 1 bus, 2 async; per-clock bounds are generous upper figures
  task automatic runConv(input int src, input logic m10, input logic ls, input logic [1:0] dv, input logic stp);
    logic [4:0] ch;
    logic       lpc;
    int         per, lim;
    code = 10'(rnd());
    ch = 5'(rnd() % NCH);
    lpc = 1'(rnd());
    per = (src == 0) ? 6 : ((src == 1) ? 2 : 8);
    lim = (lenOf(m10, ls) + 2) * per * (1 << dv) + 16 + ((src == 2) ? 5 : 0);
    sarCode <= code;
    apb(1'b1, OFF_CLOCK_CFG, (32'(src == 2) << ACLK_BIT) | (32'(lpc) << LPC_BIT) | (32'(dv) << DIV_LSB)
      | (32'(ls) << LSMP_BIT) | (32'(m10) << MODE_BIT) | (32'(src == 1) << ICLK_BIT));
    chk("oscLowPower", 32'(lpc), 32'(oscLowPower));
    stopReq <= stp;
    apb(1'b1, OFF_STATUS_CTRL, 32'(ch) | (32'h1 << IRQEN_BIT));
    waitIrq(lim, ch, src == 2);
    chk("conv time", 32'h1, 32'(cyc <= lim));
    stopReq <= 1'b0;
    checkResult(m10);
  endtask : runConv
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, stopReq} = 4'h0;
    {paddr, pwdata, sarCode, nErrors, nCompared} = '0;
    seed = 32'h0000000C;
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    apb(1'b0, OFF_STATUS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0000001F, rd);
    chk("idle", 32'h0, 32'(convActive));
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    for (int i = 0; i < 12; i++) runConv(i % 3, i[0], i[1], 2'(rnd()), 1'b0);
    runConv(2, 1'b1, 1'b0, 2'h0, 1'b1);
    // high read in mid-conversion blocks the transfer
    code = 10'(rnd());
    sarCode <= code;
    apb(1'b1, OFF_CLOCK_CFG, (32'h1 << MODE_BIT) | (32'h1 << ICLK_BIT));
    apb(1'b1, OFF_STATUS_CTRL, 32'h3 | (32'h1 << IRQEN_BIT));
    apb(1'b0, OFF_RESULT_HIGH, 32'h0);
    waitIrq(60, 5'h3, 1'b0);
    chk("blocked", 32'h1, 32'(cyc > 60));
    chk("restart", 32'h1, 32'(convActive));
    apb(1'b0, OFF_RESULT_LOW, 32'h0);
    chk("old low", lastLow, rd);
    waitIrq(60, 5'h3, 1'b0);
    chk("retry", 32'h1, 32'(cyc <= 60));
    checkResult(1'b1);
    // clock write and stop abort, results checked as kept after the clock write only
    sarCode <= ~code;
    apb(1'b1, OFF_STATUS_CTRL, 32'h5 | (32'h1 << IRQEN_BIT));
    repeat (5) @(posedge mclk);
    apb(1'b1, OFF_CLOCK_CFG, 32'h1 << ICLK_BIT);
    chk("abort", 32'h0, 32'(convActive));
    chk("abort ch", 32'h0, 32'(chanOneHot));
    repeat (60) @(posedge mclk);
    chk("no irq", 32'h0, 32'(irqReq));
    apb(1'b0, OFF_RESULT_LOW, 32'h0);
    chk("kept low", lastLow, rd);
    apb(1'b1, OFF_STATUS_CTRL, 32'h2 | (32'h1 << IRQEN_BIT));
    stopReq <= 1'b1;
    repeat (5) @(posedge mclk);
    chk("stop abort", 32'h0, 32'(convActive));
    stopReq <= 1'b0;
    // the synchronised stop lingers two cycles and would abort the next start
    repeat (3) @(posedge mclk);
    // continuous with irq masked
    apb(1'b1, OFF_STATUS_CTRL, 32'h2 | (32'h1 << CONT_BIT));
    repeat (60) @(posedge mclk);
    chk("masked irq", 32'h0, 32'(irqReq));
    apb(1'b0, OFF_STATUS_CTRL, 32'h0);
    chk("done set", 32'h1, 32'(rd[DONE_BIT]));
    chk("continuing", 32'h1, 32'(convActive));
    apb(1'b1, OFF_STATUS_CTRL, 32'h0000001F);
    repeat (40) @(posedge mclk);
    chk("powered down", 32'h0, 32'(convActive));
    // reset in mid-conversion clears results
    apb(1'b1, OFF_STATUS_CTRL, 32'h1);
    repeat (5) @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    chk("reset idle", 32'h0, 32'(convActive));
    rst_n <= 1'b1;
    @(posedge mclk);
    apb(1'b0, OFF_RESULT_LOW, 32'h0);
    chk("reset low", 32'h0, rd);
    printVerdict();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    chk("watchdog", 32'h1, 32'h0);
    printVerdict();
  end
endmodule : sar_adc_control_test
